//--- shared/ccm_pkg.sv
// What this block does
// - Calibration starts after trigger held low then high for minimum times.
// - Trigger high at power-on inhibits power-on calibration until cycled.
// - In extended mode trigger pin ORs calibration bit; both must go low first.
// - Calibration-running output is high exactly while calibration executes.
// - High power-down level stops a channel; low returns it to operation.
// - In extended mode power-down pins OR with register bits 11 and 10.
// - Outside extended mode the test-pattern pin enables the test pattern.
// - In extended mode only register bit 12 enables the test pattern.
// - Non-demux pin selects 1:1 when high, 1:2 when low, always.
// - Outside extended mode full-scale pin picks low or high range, both.
// - In extended mode ranges come from registers 3h and Bh.
// - Phase select low gives 0 degrees, high gives 90 degrees.
// - Phase selection only acts in 1:2 demultiplexed mode.
// - In extended mode phase comes from register bit 14, default 0.
// - Enable low turns on register control; test-pattern, full-scale and phase pins then ignored.
// - Enable high disables serial port, holds registers at defaults.
// - Chip select low shifts serial data; high ignores input, tri-states output.
// - Serial transfers are synchronous to the host serial clock.
// - Serial input shifts only in extended mode with chip select low.
package ccm_pkg;
  localparam logic [3:0] ADDR_MAIN = 4'h0;
  localparam logic [3:0] ADDR_I_RANGE = 4'h3;
  localparam logic [3:0] ADDR_Q_RANGE = 4'hb;
  localparam int BIT_CAL = 15;
  localparam int BIT_PHASE = 14;
  localparam int BIT_TP = 12;
  localparam int BIT_PD_I = 11;
  localparam int BIT_PD_Q = 10;
  localparam logic [15:0] MAIN_RST = 16'h0000;
  localparam logic [15:0] RANGE_MIN = 16'h0000;
  localparam logic [15:0] RANGE_MID = 16'h4000;
  localparam logic [15:0] RANGE_RST = 16'h4000;
  localparam int CMD_BITS = 8;
  localparam int FRAME_BITS = 24;
  localparam int CMD_READ_BIT = 7;
  localparam int CAL_LOW_MIN_CYC = 80;
  localparam int CAL_HIGH_MIN_CYC = 80;
  localparam int CAL_RUN_CYC = 1000;
  localparam int PON_WAIT_CYC = 4;
  localparam int PIN_CNT = 11;
  localparam logic [PIN_CNT-1:0] PIN_SYNC_RST = 11'h7ff;
  typedef struct packed {
    logic pwrdn_chan_i;
    logic pwrdn_chan_q;
    logic test_pattern;
    logic output_nondemux;
    logic output_phase_90;
  } ccm_mode_type;
  typedef enum logic [4:0] {
    ST_PON = 5'b00001,
    ST_IDLE = 5'b00010,
    ST_LOW = 5'b00100,
    ST_HIGH = 5'b01000,
    ST_RUN = 5'b10000
  } ccm_cal_state_type;
endpackage

//--- rtl/ccm_top.sv
`timescale 1ns/10ps
module ccm_top
  import ccm_pkg::*;
#(
  parameter int CAL_LOW_CYC = CAL_LOW_MIN_CYC,
  parameter int CAL_HIGH_CYC = CAL_HIGH_MIN_CYC,
  parameter int CAL_RUN_LEN = CAL_RUN_CYC
)
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic cal_trigger_in,
  input wire logic pwrdn_chan_i_in,
  input wire logic pwrdn_chan_q_in,
  input wire logic test_pattern_select_in,
  input wire logic output_nondemux_select_in,
  input wire logic full_scale_select_in,
  input wire logic output_phase_select_in,
  input wire logic ext_ctrl_enable_n_in,
  input wire logic serial_select_n_in,
  input wire logic serial_clk_in,
  input wire logic serial_in_in,
  output logic trim_active_out,
  output ccm_mode_type mode_out,
  output logic [15:0] i_range_out,
  output logic [15:0] q_range_out,
  output logic extended_control_mode_out,
  output logic serial_out_out,
  output logic serial_out_oe_out
);
  logic [PIN_CNT-1:0] pin_raw;
  logic [PIN_CNT-1:0] pin_meta_r;
  logic [PIN_CNT-1:0] pin_sync_r;
  logic sclk_prev_r;
  logic extended_control_mode;
  logic sel_active;
  logic sclk_rise;
  logic sclk_fall;
  logic cal_trig;
  assign pin_raw = {cal_trigger_in, pwrdn_chan_i_in, pwrdn_chan_q_in,
    test_pattern_select_in, output_nondemux_select_in, full_scale_select_in,
    output_phase_select_in, ext_ctrl_enable_n_in, serial_select_n_in,
    serial_clk_in, serial_in_in};
  // Two-stage synchroniser per pin
  genvar gi;
  generate
    for (gi = 0; gi < PIN_CNT; gi++)
    begin : g_sync
      always_ff @(posedge clk_in)
      begin
        if (!rst_b_in)
        begin
          pin_meta_r[gi] <= PIN_SYNC_RST[gi];
          pin_sync_r[gi] <= PIN_SYNC_RST[gi];
        end
        else
        begin
          pin_meta_r[gi] <= pin_raw[gi];
          pin_sync_r[gi] <= pin_meta_r[gi];
        end
      end
    end
  endgenerate
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
      sclk_prev_r <= 1'b1;
    else
      sclk_prev_r <= pin_sync_r[1];
  end
  assign extended_control_mode = ~pin_sync_r[3];
  // Port active only with chip select low
  assign sel_active = extended_control_mode & ~pin_sync_r[2];
  // Edges of the host serial clock
  assign sclk_rise = pin_sync_r[1] & ~sclk_prev_r;
  assign sclk_fall = ~pin_sync_r[1] & sclk_prev_r;
  logic [15:0] main_r;
  logic [15:0] main_nxt;
  logic [15:0] irng_r;
  logic [15:0] irng_nxt;
  logic [15:0] qrng_r;
  logic [15:0] qrng_nxt;
  logic [4:0] bitcnt_r;
  logic [4:0] bitcnt_nxt;
  logic [23:0] shift_r;
  logic [23:0] shift_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic rd_r;
  logic rd_nxt;
  logic sdo_r;
  logic sdo_nxt;
  logic [3:0] cmd_addr;
  logic [15:0] rd_val;
  assign cmd_addr = shift_r[3:0];
  // Addressed register on the first read bit, then the shifted copy
  assign rd_val = (bitcnt_r != 5'(CMD_BITS)) ? rdata_r :
    (cmd_addr == ADDR_MAIN) ? main_r :
    (cmd_addr == ADDR_I_RANGE) ? irng_r :
    (cmd_addr == ADDR_Q_RANGE) ? qrng_r : 16'h0000;
  always_comb
  begin
    main_nxt = main_r;
    irng_nxt = irng_r;
    qrng_nxt = qrng_r;
    bitcnt_nxt = bitcnt_r;
    shift_nxt = shift_r;
    rdata_nxt = rdata_r;
    rd_nxt = rd_r;
    sdo_nxt = sdo_r;
    if (!sel_active)
    begin
      bitcnt_nxt = 5'h00;
      rd_nxt = 1'b0;
      sdo_nxt = 1'b0;
    end
    else
    begin
      if (sclk_rise && bitcnt_r < 5'(FRAME_BITS))
      begin
        shift_nxt = {shift_r[22:0], pin_sync_r[0]};
        bitcnt_nxt = bitcnt_r + 5'h01;
        if (bitcnt_r == 5'(CMD_BITS - 1))
          rd_nxt = shift_r[CMD_READ_BIT - 1];
        if (bitcnt_r == 5'(FRAME_BITS - 1) && !rd_r)
        begin
          case (shift_r[FRAME_BITS - CMD_BITS + 2:FRAME_BITS - CMD_BITS - 1])
            ADDR_MAIN: main_nxt = {shift_r[14:0], pin_sync_r[0]};
            ADDR_I_RANGE: irng_nxt = {shift_r[14:0], pin_sync_r[0]};
            ADDR_Q_RANGE: qrng_nxt = {shift_r[14:0], pin_sync_r[0]};
            default: main_nxt = main_r;
          endcase
        end
      end
      // Read data leaves on falling edges
      if (sclk_fall && rd_r && bitcnt_r >= 5'(CMD_BITS)
        && bitcnt_r < 5'(FRAME_BITS))
      begin
        sdo_nxt = rd_val[15];
        rdata_nxt = {rd_val[14:0], 1'b0};
      end
    end
    if (!extended_control_mode)
    begin
      main_nxt = MAIN_RST;
      irng_nxt = RANGE_RST;
      qrng_nxt = RANGE_RST;
    end
  end
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      main_r <= MAIN_RST;
      irng_r <= RANGE_RST;
      qrng_r <= RANGE_RST;
      bitcnt_r <= 5'h00;
      shift_r <= 24'h000000;
      rdata_r <= 16'h0000;
      rd_r <= 1'b0;
      sdo_r <= 1'b0;
    end
    else
    begin
      main_r <= main_nxt;
      irng_r <= irng_nxt;
      qrng_r <= qrng_nxt;
      bitcnt_r <= bitcnt_nxt;
      shift_r <= shift_nxt;
      rdata_r <= rdata_nxt;
      rd_r <= rd_nxt;
      sdo_r <= sdo_nxt;
    end
  end
  assign serial_out_out = sdo_r;
  assign serial_out_oe_out = sel_active;
  ccm_cal_state_type st_r;
  ccm_cal_state_type st_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  // Pin ORed with control bit in extended mode
  assign cal_trig = pin_sync_r[10] | (extended_control_mode & main_r[BIT_CAL]);
  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r + 16'h0001;
    case (st_r)
      ST_PON:
      begin
        // Power-on calibration unless trigger is high
        if (cnt_r == 16'(PON_WAIT_CYC - 1))
        begin
          st_nxt = cal_trig ? ST_IDLE : ST_RUN;
          cnt_nxt = 16'h0000;
        end
      end
      ST_IDLE:
      begin
        cnt_nxt = 16'h0000;
        if (!cal_trig)
          st_nxt = ST_LOW;
      end
      ST_LOW:
      begin
        if (cal_trig)
        begin
          st_nxt = (cnt_r >= 16'(CAL_LOW_CYC - 1)) ? ST_HIGH : ST_IDLE;
          cnt_nxt = 16'h0000;
        end
        else if (cnt_r == 16'hffff)
          cnt_nxt = cnt_r;
      end
      ST_HIGH:
      begin
        if (!cal_trig)
        begin
          st_nxt = ST_LOW;
          cnt_nxt = 16'h0000;
        end
        else if (cnt_r == 16'(CAL_HIGH_CYC - 2))
        begin
          st_nxt = ST_RUN;
          cnt_nxt = 16'h0000;
        end
      end
      ST_RUN:
      begin
        if (cnt_r == 16'(CAL_RUN_LEN - 1))
        begin
          st_nxt = ST_IDLE;
          cnt_nxt = 16'h0000;
        end
      end
      default:
      begin
        st_nxt = ST_IDLE;
        cnt_nxt = 16'h0000;
      end
    endcase
  end
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      st_r <= ST_PON;
      cnt_r <= 16'h0000;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  // Running flag follows the run state
  assign trim_active_out = (st_r == ST_RUN);
  ccm_mode_type mode_r;
  ccm_mode_type mode_nxt;
  logic [15:0] ir_r;
  logic [15:0] ir_nxt;
  logic [15:0] qr_r;
  logic [15:0] qr_nxt;
  always_comb
  begin
    mode_nxt.pwrdn_chan_i = pin_sync_r[9] | (extended_control_mode & main_r[BIT_PD_I]);
    mode_nxt.pwrdn_chan_q = pin_sync_r[8] | (extended_control_mode & main_r[BIT_PD_Q]);
    mode_nxt.test_pattern = extended_control_mode ? main_r[BIT_TP] : pin_sync_r[7];
    mode_nxt.output_nondemux = pin_sync_r[6];
    mode_nxt.output_phase_90 = ~pin_sync_r[6] &
      (extended_control_mode ? main_r[BIT_PHASE] : pin_sync_r[4]);
    ir_nxt = extended_control_mode ? irng_r : (pin_sync_r[5] ? RANGE_MID : RANGE_MIN);
    qr_nxt = extended_control_mode ? qrng_r : (pin_sync_r[5] ? RANGE_MID : RANGE_MIN);
  end
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      mode_r <= '0;
      ir_r <= RANGE_MIN;
      qr_r <= RANGE_MIN;
    end
    else
    begin
      mode_r <= mode_nxt;
      ir_r <= ir_nxt;
      qr_r <= qr_nxt;
    end
  end
  assign mode_out = mode_r;
  assign i_range_out = ir_r;
  assign q_range_out = qr_r;
  assign extended_control_mode_out = extended_control_mode;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  sequence s_high_done;
    st_r == ST_HIGH && cal_trig && cnt_r == 16'(CAL_HIGH_CYC - 2);
  endsequence
  sequence s_run_end;
    st_r == ST_RUN && cnt_r == 16'(CAL_RUN_LEN - 1);
  endsequence
  AST_CAL_START: assert property (s_high_done |=> trim_active_out)
    else $error("calibration did not start after high time");
  AST_PON_INHIBIT: assert property (
    st_r == ST_PON && cnt_r == 16'(PON_WAIT_CYC - 1) && cal_trig
    |=> !trim_active_out ##0 st_r == ST_IDLE)
    else $error("power-on calibration not inhibited");
  AST_IDLE_NO_CAL: assert property (st_r == ST_IDLE |=> !trim_active_out)
    else $error("calibration started without low phase");
  AST_RUN_END: assert property (s_run_end |=> !trim_active_out)
    else $error("running flag outlasted calibration");
  AST_PD_I: assert property (
    extended_control_mode && main_r[BIT_PD_I] |=> mode_out.pwrdn_chan_i)
    else $error("register power-down ignored");
  AST_TP_ECM: assert property (
    extended_control_mode && !main_r[BIT_TP] |=> !mode_out.test_pattern)
    else $error("test pattern pin not ignored");
  AST_PHASE_DEMUX: assert property (
    mode_out.output_nondemux |-> !mode_out.output_phase_90)
    else $error("phase active in non-demux mode");
  AST_REG_DEFAULT: assert property (!extended_control_mode |=> main_r == MAIN_RST)
    else $error("registers not held at default");
  AST_SDO_TRI: assert property (
    pin_sync_r[2] |-> !serial_out_oe_out)
    else $error("serial output driven while deselected");
  AST_NO_SHIFT: assert property (
    !sel_active |=> bitcnt_r == 5'h00 ##0 $stable(shift_r))
    else $error("serial input shifted while deselected");
endmodule

//--- verification/ccm_host.sv
`timescale 1ns/10ps
module ccm_host
  import ccm_pkg::*;
(
  input wire logic clk_in,
  input wire logic sdo_in,
  input wire logic oe_in,
  output logic sclk_out,
  output logic sdi_out,
  output logic sel_n_out,
  output logic oe_mid_out
);
  initial
  begin
    sclk_out = 1'b0;
    sdi_out = 1'b0;
    sel_n_out = 1'b1;
    oe_mid_out = 1'b0;
  end
  // Half of a 320 ns serial clock period
  task automatic half();
    repeat (4) @(negedge clk_in);
  endtask
  // clock idles low, data set before rise
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd,
    input logic sel, output logic [15:0] rd);
    logic [23:0] fr;
    fr = {cmd, wd};
    rd = 16'h0000;
    sel_n_out = ~sel;
    half();
    for (int i = 0; i < FRAME_BITS; i++)
    begin
      sdi_out = fr[23 - i];
      half();
      if (i >= CMD_BITS)
        rd = {rd[14:0], sdo_in};
      if (i == 12)
        oe_mid_out = oe_in;
      sclk_out = 1'b1;
      half();
      sclk_out = 1'b0;
    end
    half();
    sel_n_out = 1'b1;
    // Released line shows no stale level
    sdi_out = ~sdi_out;
    half();
    half();
  endtask
endmodule

//--- verification/ccm_top_bench.sv
`timescale 1ns/10ps
module ccm_top_bench
  import ccm_pkg::*;
;
  localparam int RUN_C = 20;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic cal_trigger_in = 1'b1;
  logic ece_n = 1'b1;
  logic [5:0] pins = 6'h00;
  logic sclk, serial_in, sel_n, oe_mid, trim, extended_control_mode, serial_out, oe;
  ccm_mode_type mode_out;
  logic [15:0] i_rng, q_rng, rd;
  logic [15:0] exp_main = 16'h0000;
  logic [15:0] exp_i = 16'h4000;
  logic [15:0] exp_q = 16'h4000;
  int errors = 0;
  int cmp_count = 0;
  int run_len = 0;
  int cal_q[$];
  logic [15:0] rd_q[$];
  event rd_done;
  always #20 clk_in = ~clk_in;
  ccm_top #(.CAL_LOW_CYC(4), .CAL_HIGH_CYC(4), .CAL_RUN_LEN(RUN_C)) uut (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .cal_trigger_in(cal_trigger_in),
    .pwrdn_chan_i_in(pins[5]),
    .pwrdn_chan_q_in(pins[4]),
    .test_pattern_select_in(pins[3]),
    .output_nondemux_select_in(pins[2]),
    .full_scale_select_in(pins[1]),
    .output_phase_select_in(pins[0]),
    .ext_ctrl_enable_n_in(ece_n),
    .serial_select_n_in(sel_n),
    .serial_clk_in(sclk),
    .serial_in_in(serial_in),
    .trim_active_out(trim),
    .mode_out(mode_out),
    .i_range_out(i_rng),
    .q_range_out(q_rng),
    .extended_control_mode_out(extended_control_mode),
    .serial_out_out(serial_out),
    .serial_out_oe_out(oe)
  );
  ccm_host host (
    .clk_in(clk_in),
    .sdo_in(serial_out),
    .oe_in(oe),
    .sclk_out(sclk),
    .sdi_out(serial_in),
    .sel_n_out(sel_n),
    .oe_mid_out(oe_mid)
  );
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cmp16(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cmp_mode(input ccm_mode_type e, input ccm_mode_type g);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected mode exp %b got %b", e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d,
    input logic sel);
    logic [15:0] r;
    // Command bits 6:4 are don't-care, so they are randomised
    host.xfer({1'b0, 3'($urandom), a}, d, sel, r);
  endtask
  task automatic rdq(input logic [3:0] a, input logic [15:0] e);
    rd_q.push_back(e);
    host.xfer({1'b1, 3'($urandom), a}, 16'h0000, 1'b1, rd);
    ->rd_done;
  endtask
  task automatic chk_pins(input logic x);
    ccm_mode_type e;
    logic [15:0] fs;
    fs = pins[1] ? RANGE_MID : RANGE_MIN;
    e.pwrdn_chan_i = pins[5] | (x & exp_main[BIT_PD_I]);
    e.pwrdn_chan_q = pins[4] | (x & exp_main[BIT_PD_Q]);
    e.test_pattern = x ? exp_main[BIT_TP] : pins[3];
    e.output_nondemux = pins[2];
    e.output_phase_90 = ~pins[2] & (x ? exp_main[BIT_PHASE] : pins[0]);
    cmp_mode(e, mode_out);
    cmp16("i_range", x ? exp_i : fs, i_rng);
    cmp16("q_range", x ? exp_q : fs, q_rng);
    cmp16("ext_mode", {15'h0, x}, {15'h0, extended_control_mode});
  endtask
  task automatic rand_pins(input logic x);
    repeat (12)
    begin
      pins = 6'($urandom);
      cyc(4);
      chk_pins(x);
    end
  endtask
  always @(rd_done)
    cmp16("read", rd_q.pop_front(), rd);
  // Each calibration pulse is measured when it ends
  always @(negedge clk_in)
  begin
    if (trim === 1'b1)
      run_len++;
    else if (run_len != 0)
    begin
      if (cal_q.size() == 0)
        cmp16("trim_len", 16'h0, 16'(run_len));
      else
        cmp16("trim_len", 16'(cal_q.pop_front()), 16'(run_len));
      run_len = 0;
    end
  end
  initial
  begin
    cyc(20000);
    errors++;
    $display("unexpected timeout exp done got hung");
    end_of_test();
  end
  initial
  begin
    void'($urandom(32'h20f6));
    cyc(2);
    rst_b_in = 1'b1;
    cyc(40);
    cmp16("trim", 16'h0, {15'h0, trim});
    cal_trigger_in = 1'b0;
    cyc(1);
    cal_trigger_in = 1'b1;
    cyc(40);
    cal_q.push_back(RUN_C);
    cal_trigger_in = 1'b0;
    cyc(8);
    cal_trigger_in = 1'b1;
    cyc(RUN_C + 20);
    cal_trigger_in = 1'b0;
    rand_pins(1'b0);
    wr(ADDR_MAIN, 16'h5c00, 1'b1);
    ece_n = 1'b0;
    cyc(4);
    rdq(ADDR_MAIN, MAIN_RST);
    rdq(ADDR_I_RANGE, RANGE_RST);
    rdq(ADDR_Q_RANGE, RANGE_RST);
    cmp16("oe_mid", 16'h1, {15'h0, oe_mid});
    exp_main = 16'h5c00;
    exp_i = 16'h1234;
    exp_q = 16'habcd;
    wr(ADDR_MAIN, exp_main, 1'b1);
    wr(ADDR_I_RANGE, exp_i, 1'b1);
    wr(ADDR_Q_RANGE, exp_q, 1'b1);
    wr(4'h5, 16'hffff, 1'b1);
    wr(ADDR_MAIN, 16'hffff, 1'b0);
    rdq(ADDR_MAIN, exp_main);
    rdq(ADDR_I_RANGE, exp_i);
    rdq(ADDR_Q_RANGE, exp_q);
    rdq(4'h5, 16'h0000);
    cmp16("oe_idle", 16'h0, {15'h0, oe});
    rand_pins(1'b1);
    cal_q.push_back(RUN_C);
    wr(ADDR_MAIN, 16'h8000, 1'b1);
    cyc(RUN_C + 20);
    wr(ADDR_MAIN, 16'h0000, 1'b1);
    ece_n = 1'b1;
    cyc(4);
    ece_n = 1'b0;
    cyc(4);
    rdq(ADDR_I_RANGE, RANGE_RST);
    cyc(4);
    // Second reset with the trigger low: power-on calibration runs
    cal_q.push_back(RUN_C);
    rst_b_in = 1'b0;
    cyc(2);
    rst_b_in = 1'b1;
    cyc(2);
    cmp16("trim_rst", 16'h0, {15'h0, trim});
    cyc(RUN_C + 20);
    cmp16("cal_left", 16'h0, 16'(cal_q.size()));
    end_of_test();
  end
endmodule
